// [rtl/bl_cfg.svh]
// Constants for the byte-load decode and execute block
`ifndef BL_CFG_SVH
`define BL_CFG_SVH

// ****************************************
// Encoding fields
// ****************************************
`define BL_OP_HI      31:20
`define BL_OP_WIDE    12'hF81
`define BL_LIT_HI     31:24
`define BL_LIT_OP     8'hF8
`define BL_LIT_MID    22:16
`define BL_LIT_PAT    7'h1F
`define BL_DIR_BIT    23
`define BL_BASE_W     19:16
`define BL_DEST_W     15:12
`define BL_REG_GAP    11:6
`define BL_REG_ZERO   6'h00
`define BL_UNP_SEL    11:8
`define BL_UNP_PAT    4'hE
`define BL_SHIFT_F    5:4
`define BL_INDEX_W    3:0
`define BL_LONG_OFFSET_FIELD      11:0
`define BL_SHORT_OFFSET_FIELD       7:0
`define BL_OP_SHORT   15:9
`define BL_SHORT_PAT  7'h2E
`define BL_INDEX_S    8:6
`define BL_BASE_S     5:3
`define BL_DEST_S     2:0

// ****************************************
// Register numbers and values
// ****************************************
`define BL_REG_ALL1   4'hF
`define BL_REG_SP     4'hD
`define BL_ALIGN_MASK 32'hFFFF_FFFC
`define BL_PAD_ZERO   24'h00_0000
`define BL_SHIFT_NONE 2'h0

`endif

// [rtl/bl_pkg.sv]
// Types shared by the byte-load decode and execute block
package bl_pkg;
    typedef enum logic [1:0] {FORM_NONE, FORM_LIT, FORM_REG, FORM_UNPRIV} form_t;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_MEM, ST_FIN} state_t;
endpackage

// [rtl/bl_decoder.sv]
// Instruction decoder for the byte-load group
`include "bl_cfg.svh"
module bl_decoder (
    // Instruction
    input  wire logic [31:0]       instr,
    input  wire logic              wide,
    input  wire logic              main_ext,
    // Decoded fields
    output bl_pkg::form_t          form,
    output logic      [3:0]        dest_reg_field,
    output logic      [3:0]        base_reg_field,
    output logic      [3:0]        index_reg_field,
    output logic      [11:0]       long_offset_field,
    output logic      [1:0]        shift_amount_field,
    output logic                   add_sel,
    output logic                   preload_hint,
    output logic                   undef,
    output logic                   unpred
);
    import bl_pkg::*;

    logic wide_grp;
    logic lit_enc;

    // Base of all ones inside the wide group falls through to the literal form
    assign wide_grp = wide && (instr[`BL_OP_HI] == `BL_OP_WIDE);
    assign lit_enc  = wide && (instr[`BL_LIT_HI] == `BL_LIT_OP)
                      && (instr[`BL_LIT_MID] == `BL_LIT_PAT);

    // Field extraction and classification
    always_comb begin
        form               = FORM_NONE;
        dest_reg_field     = instr[`BL_DEST_W];
        base_reg_field     = instr[`BL_BASE_W];
        index_reg_field    = instr[`BL_INDEX_W];
        long_offset_field  = instr[`BL_LONG_OFFSET_FIELD];
        shift_amount_field = instr[`BL_SHIFT_F];
        add_sel            = 1'b1;
        preload_hint       = 1'b0;
        undef              = 1'b0;
        unpred             = 1'b0;
        if (lit_enc) begin
            form    = FORM_LIT;
            add_sel = instr[`BL_DIR_BIT];
            preload_hint = (dest_reg_field == `BL_REG_ALL1);
            undef   = !preload_hint && !main_ext;
            unpred  = (dest_reg_field == `BL_REG_SP);
        end else if (wide_grp && instr[`BL_REG_GAP] == `BL_REG_ZERO) begin
            form    = FORM_REG;
            preload_hint = (dest_reg_field == `BL_REG_ALL1);
            undef   = !preload_hint && !main_ext;
            unpred  = (dest_reg_field == `BL_REG_SP)
                      || (index_reg_field == `BL_REG_SP)
                      || (index_reg_field == `BL_REG_ALL1);
        end else if (wide_grp && instr[`BL_UNP_SEL] == `BL_UNP_PAT) begin
            form    = FORM_UNPRIV;
            long_offset_field = {4'h0, instr[`BL_SHORT_OFFSET_FIELD]};
            undef   = !main_ext;
            unpred  = (dest_reg_field == `BL_REG_SP)
                      || (dest_reg_field == `BL_REG_ALL1);
        end else if (!wide && instr[`BL_OP_SHORT] == `BL_SHORT_PAT) begin
            form               = FORM_REG;
            dest_reg_field     = {1'b0, instr[`BL_DEST_S]};
            base_reg_field     = {1'b0, instr[`BL_BASE_S]};
            index_reg_field    = {1'b0, instr[`BL_INDEX_S]};
            shift_amount_field = `BL_SHIFT_NONE;
        end
    end
endmodule

// [rtl/bl_addr_unit.sv]
// Address generation for the byte-load forms
`include "bl_cfg.svh"
module bl_addr_unit #(
    parameter int AW = 32
) (
    // Operands
    input  bl_pkg::form_t          form,
    input  wire logic [AW-1:0]     pc,
    input  wire logic [AW-1:0]     base_val,
    input  wire logic [AW-1:0]     index_val,
    input  wire logic [11:0]       offset,
    input  wire logic [1:0]        shift_amt,
    input  wire logic              add_sel,
    input  wire logic              carry_in,
    // Result
    output logic      [AW-1:0]     addr
);
    import bl_pkg::*;

    // Left shift; carry only matters for a carry-out, which loads discard
    function automatic logic [AW-1:0] shift_lsl(input logic [AW-1:0] v,
                                                input logic [1:0] n,
                                                input logic c);
        logic [AW:0] r;
        r = {c, v} << n;
        return r[AW-1:0];
    endfunction

    logic [AW-1:0] lit_base;
    logic [AW-1:0] imm_ext;

    assign lit_base = pc & AW'(`BL_ALIGN_MASK);
    assign imm_ext  = AW'(offset);

    // Form selects the address arithmetic
    always_comb begin
        unique case (form)
            FORM_LIT:    addr = add_sel ? lit_base + imm_ext
                                        : lit_base - imm_ext;
            FORM_REG:    addr = base_val
                                + shift_lsl(index_val, shift_amt, carry_in);
            FORM_UNPRIV: addr = base_val + imm_ext;
            FORM_NONE:   addr = base_val;
        endcase
    end
endmodule

// [rtl/byte_load_decode_execute.sv]
// Byte-load decode and execute block: issue, register read, memory access, writeback
`include "bl_cfg.svh"
module byte_load_decode_execute (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              NRST,
    // Issue
    input  wire logic              ISSUE_VALID,
    input  wire logic              ISSUE_WIDE,
    input  wire logic [31:0]       ISSUE_INSTR,
    input  wire logic [31:0]       ISSUE_PC,
    input  wire logic              COND_PASS,
    input  wire logic              MAIN_EXT,
    input  wire logic              CARRY_FLAG,
    output logic                   ISSUE_READY,
    // Register file read
    output logic      [3:0]        RF_RADDR_BASE,
    output logic      [3:0]        RF_RADDR_INDEX,
    input  wire logic [31:0]       RF_RDATA_BASE,
    input  wire logic [31:0]       RF_RDATA_INDEX,
    // Memory access
    output logic                   MEM_REQ,
    output logic      [31:0]       MEM_ADDR,
    output logic                   MEM_UNPRIV,
    input  wire logic              MEM_ACK,
    input  wire logic [7:0]        MEM_RDATA,
    // Register file write
    output logic                   RF_WE,
    output logic      [3:0]        RF_WADDR,
    output logic      [31:0]       RF_WDATA,
    // Completion status
    output logic                   DONE,
    output logic                   UNDEF,
    output logic                   HINT,
    output logic                   UNPRED,
    output logic                   NOT_MINE
);
    import bl_pkg::*;

    // ****************************************
    // Decode of the instruction on offer
    // ****************************************
    form_t       dec_form;
    logic [3:0]  dec_dest;
    logic [3:0]  dec_base;
    logic [3:0]  dec_index;
    logic [11:0] dec_imm;
    logic [1:0]  dec_shift;
    logic        dec_add;
    logic        dec_hint;
    logic        dec_undef;
    logic        dec_unpred;

    bl_decoder u_dec (
        .instr              (ISSUE_INSTR),
        .wide               (ISSUE_WIDE),
        .main_ext           (MAIN_EXT),
        .form               (dec_form),
        .dest_reg_field     (dec_dest),
        .base_reg_field     (dec_base),
        .index_reg_field    (dec_index),
        .long_offset_field  (dec_imm),
        .shift_amount_field (dec_shift),
        .add_sel            (dec_add),
        .preload_hint       (dec_hint),
        .undef              (dec_undef),
        .unpred             (dec_unpred)
    );

    // ****************************************
    // State
    // ****************************************
    state_t      state_ff,  nxt_state;
    form_t       form_ff,   nxt_form;
    logic [31:0] pc_ff,     nxt_pc;
    logic [11:0] imm_ff,    nxt_imm;
    logic [1:0]  shift_ff,  nxt_shift;
    logic        add_ff,    nxt_add;
    logic        carry_ff,  nxt_carry;
    logic        cond_ff,   nxt_cond;
    logic [3:0]  rbase_ff,  nxt_rbase;
    logic [3:0]  rindex_ff, nxt_rindex;
    logic [3:0]  waddr_ff,  nxt_waddr;
    logic [31:0] wdata_ff,  nxt_wdata;
    logic [31:0] maddr_ff,  nxt_maddr;
    logic        mreq_ff,   nxt_mreq;
    logic        munp_ff,   nxt_munp;
    logic        we_ff,     nxt_we;
    logic        done_ff,   nxt_done;
    logic        undef_ff,  nxt_undef;
    logic        hint_ff,   nxt_hint;
    logic        unpred_ff, nxt_unpred;
    logic        foreign_ff, nxt_foreign;
    logic        ready_ff,  nxt_ready;
    logic [31:0] calc_addr;
    logic        take;

    assign take = ISSUE_VALID && ready_ff;

    // Address arithmetic on operands read in the register-read cycle
    bl_addr_unit #(
        .AW (32)
    ) u_addr (
        .form      (form_ff),
        .pc        (pc_ff),
        .base_val  (RF_RDATA_BASE),
        .index_val (RF_RDATA_INDEX),
        .offset    (imm_ff),
        .shift_amt (shift_ff),
        .add_sel   (add_ff),
        .carry_in  (carry_ff),
        .addr      (calc_addr)
    );

    // ****************************************
    // Sequencer next state
    // ****************************************
    // DONE and RF_WE pulse for one cycle; status flags hold until cleared in idle; operand latches hold until the next issue
    always_comb begin
        nxt_state   = state_ff;
        nxt_form    = form_ff;
        nxt_pc      = pc_ff;
        nxt_imm     = imm_ff;
        nxt_shift   = shift_ff;
        nxt_add     = add_ff;
        nxt_carry   = carry_ff;
        nxt_cond    = cond_ff;
        nxt_rbase   = rbase_ff;
        nxt_rindex  = rindex_ff;
        nxt_waddr   = waddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_maddr   = maddr_ff;
        nxt_mreq    = mreq_ff;
        nxt_munp    = munp_ff;
        nxt_we      = 1'b0;
        nxt_done    = 1'b0;
        nxt_undef   = undef_ff;
        nxt_hint    = hint_ff;
        nxt_unpred  = unpred_ff;
        nxt_foreign = foreign_ff;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_undef   = 1'b0;
                nxt_hint    = 1'b0;
                nxt_unpred  = 1'b0;
                nxt_foreign = 1'b0;
                if (take) begin
                    nxt_form   = dec_form;
                    nxt_pc     = ISSUE_PC;
                    nxt_imm    = dec_imm;
                    nxt_shift  = dec_shift;
                    nxt_add    = dec_add;
                    nxt_carry  = CARRY_FLAG;
                    nxt_cond   = COND_PASS;
                    nxt_rbase  = dec_base;
                    nxt_rindex = dec_index;
                    nxt_waddr  = dec_dest;
                    nxt_state  = ST_FIN;
                    // Hint, undefined and foreign encodings finish without effect
                    if (dec_form == FORM_NONE) begin
                        nxt_foreign = 1'b1;
                    end else if (dec_hint) begin
                        nxt_hint = 1'b1;
                    end else if (dec_undef) begin
                        nxt_undef = 1'b1;
                    end else if (COND_PASS) begin
                        nxt_unpred = dec_unpred;
                        nxt_state  = ST_READ;
                    end
                    nxt_done = (nxt_state == ST_FIN);
                end
            end
            ST_READ: begin
                nxt_maddr = calc_addr;
                nxt_mreq  = 1'b1;
                nxt_munp  = (form_ff == FORM_UNPRIV);
                nxt_state = ST_MEM;
            end
            ST_MEM: begin
                if (MEM_ACK) begin
                    nxt_mreq  = 1'b0;
                    nxt_munp  = 1'b0;
                    nxt_wdata = {`BL_PAD_ZERO, MEM_RDATA};
                    nxt_we    = 1'b1;
                    nxt_done  = 1'b1;
                    nxt_state = ST_FIN;
                end
            end
            ST_FIN: begin
                nxt_state = ST_IDLE;
            end
        endcase
        nxt_ready = (nxt_state == ST_IDLE);
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_ff   <= ST_IDLE;
            form_ff    <= FORM_NONE;
            pc_ff      <= 32'h0000_0000;
            imm_ff     <= 12'h000;
            shift_ff   <= 2'h0;
            add_ff     <= 1'b0;
            carry_ff   <= 1'b0;
            cond_ff    <= 1'b0;
            rbase_ff   <= 4'h0;
            rindex_ff  <= 4'h0;
            waddr_ff   <= 4'h0;
            wdata_ff   <= 32'h0000_0000;
            maddr_ff   <= 32'h0000_0000;
            mreq_ff    <= 1'b0;
            munp_ff    <= 1'b0;
            we_ff      <= 1'b0;
            done_ff    <= 1'b0;
            undef_ff   <= 1'b0;
            hint_ff    <= 1'b0;
            unpred_ff  <= 1'b0;
            foreign_ff <= 1'b0;
            ready_ff   <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            form_ff    <= nxt_form;
            pc_ff      <= nxt_pc;
            imm_ff     <= nxt_imm;
            shift_ff   <= nxt_shift;
            add_ff     <= nxt_add;
            carry_ff   <= nxt_carry;
            cond_ff    <= nxt_cond;
            rbase_ff   <= nxt_rbase;
            rindex_ff  <= nxt_rindex;
            waddr_ff   <= nxt_waddr;
            wdata_ff   <= nxt_wdata;
            maddr_ff   <= nxt_maddr;
            mreq_ff    <= nxt_mreq;
            munp_ff    <= nxt_munp;
            we_ff      <= nxt_we;
            done_ff    <= nxt_done;
            undef_ff   <= nxt_undef;
            hint_ff    <= nxt_hint;
            unpred_ff  <= nxt_unpred;
            foreign_ff <= nxt_foreign;
            ready_ff   <= nxt_ready;
        end
    end

    // ****************************************
    // Outputs, all straight from flops
    // ****************************************
    assign ISSUE_READY    = ready_ff;
    assign RF_RADDR_BASE  = rbase_ff;
    assign RF_RADDR_INDEX = rindex_ff;
    assign MEM_REQ        = mreq_ff;
    assign MEM_ADDR       = maddr_ff;
    assign MEM_UNPRIV     = munp_ff;
    assign RF_WE          = we_ff;
    assign RF_WADDR       = waddr_ff;
    assign RF_WDATA       = wdata_ff;
    assign DONE           = done_ff;
    assign UNDEF          = undef_ff;
    assign HINT           = hint_ff;
    assign UNPRED         = unpred_ff;
    assign NOT_MINE       = foreign_ff;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_byte_pad: assert property (RF_WE |-> RF_WDATA[31:8] == `BL_PAD_ZERO)
        else $error("Loaded byte not zero-extended");
    chk_byte_data: assert property (RF_WE
        |-> RF_WDATA[7:0] == $past(MEM_RDATA) && $past(MEM_ACK))
        else $error("Written byte differs from memory byte");
    chk_lit_addr: assert property ($rose(MEM_REQ) && form_ff == FORM_LIT
        |-> MEM_ADDR == (add_ff ? (pc_ff & `BL_ALIGN_MASK) + {20'h0_0000, imm_ff}
                                : (pc_ff & `BL_ALIGN_MASK) - {20'h0_0000, imm_ff}))
        else $error("Literal address wrong");
    // A zero offset leaves the aligned base whichever direction is chosen
    chk_lit_align: assert property ($rose(MEM_REQ) && form_ff == FORM_LIT
        && imm_ff == 12'h000 |-> MEM_ADDR[1:0] == 2'h0)
        else $error("Literal base not word aligned");
    chk_reg_addr: assert property ($rose(MEM_REQ) && form_ff == FORM_REG
        |-> MEM_ADDR == $past(RF_RDATA_BASE) + ($past(RF_RDATA_INDEX) << shift_ff))
        else $error("Register-offset address wrong");
    chk_unpriv_flag: assert property (MEM_REQ
        |-> MEM_UNPRIV == (form_ff == FORM_UNPRIV))
        else $error("Unprivileged attribute wrong");
    chk_unpriv_addr: assert property ($rose(MEM_REQ) && form_ff == FORM_UNPRIV
        |-> MEM_ADDR == $past(RF_RDATA_BASE) + {24'h00_0000, imm_ff[7:0]})
        else $error("Unprivileged address wrong");
    chk_cond_fail: assert property (take && !COND_PASS
        |=> !MEM_REQ && DONE ##1 !RF_WE)
        else $error("Failed condition had an effect");
    chk_hint_quiet: assert property (take && dec_hint && dec_form != FORM_UNPRIV
        |=> HINT && DONE && !MEM_REQ ##1 !RF_WE)
        else $error("Preload hint not redirected");
    chk_undef_quiet: assert property (take && !MAIN_EXT && ISSUE_WIDE
        && dec_form != FORM_NONE && !dec_hint |=> UNDEF && !MEM_REQ)
        else $error("Missing main extension not undefined");
    chk_short_shift: assert property (take && !ISSUE_WIDE && dec_form == FORM_REG
        |=> shift_ff == `BL_SHIFT_NONE)
        else $error("Short form shifted index");

    cov_literal: cover property (RF_WE && form_ff == FORM_LIT && !add_ff);
    cov_wide_shift: cover property (RF_WE && form_ff == FORM_REG && shift_ff == 2'h3);
    cov_unpriv: cover property (RF_WE && form_ff == FORM_UNPRIV);
    cov_cond_fail: cover property (take && !COND_PASS && dec_form != FORM_NONE);
endmodule

// [bench/bl_mem_model.sv]
// Memory access unit and register file model facing the byte-load block
module bl_mem_model (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // Bench control: register contents seed and memory wait
    input  wire logic [31:0] salt,
    input  wire logic [2:0]  lat,
    // Register file read
    input  wire logic [3:0]  RF_RADDR_BASE,
    input  wire logic [3:0]  RF_RADDR_INDEX,
    output logic      [31:0] RF_RDATA_BASE,
    output logic      [31:0] RF_RDATA_INDEX,
    // Memory access
    input  wire logic        MEM_REQ,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic        MEM_UNPRIV,
    output logic             MEM_ACK,
    output logic      [7:0]  MEM_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_ff;
    logic [7:0] last_ff;
    // Register contents follow the seed so every load sees fresh values
    assign RF_RDATA_BASE  = salt ^ ({28'h0, RF_RADDR_BASE} * 32'h1111_1111);
    assign RF_RDATA_INDEX = salt ^ ({28'h0, RF_RADDR_INDEX} * 32'h1111_1111);
    // Ack after lat waiting cycles, zero means in the first request cycle
    assign MEM_ACK   = MEM_REQ && (wait_ff == lat);
    // Data is only valid with ack; otherwise show the inverse of the last byte
    assign MEM_RDATA = MEM_ACK ? (MEM_ADDR[7:0] ^ MEM_ADDR[15:8] ^ {MEM_UNPRIV, 7'h00})
                               : ~last_ff;
    // Wait counter and last byte
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wait_ff <= 3'h0;
            last_ff <= 8'h00;
        end else begin
            wait_ff <= (MEM_REQ && !MEM_ACK) ? wait_ff + 3'h1 : 3'h0;
            if (MEM_ACK) begin
                last_ff <= MEM_RDATA;
            end
        end
    end
endmodule

// [bench/tb.sv]
// Self-checking bench for the byte-load decode and execute block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'b0;
    logic        NRST, ISSUE_VALID, ISSUE_WIDE, COND_PASS, MAIN_EXT, CARRY_FLAG;
    logic [31:0] ISSUE_INSTR, ISSUE_PC, RF_RDATA_BASE, RF_RDATA_INDEX, MEM_ADDR, RF_WDATA, salt;
    logic [3:0]  RF_RADDR_BASE, RF_RADDR_INDEX, RF_WADDR;
    logic [7:0]  MEM_RDATA;
    logic [2:0]  lat;
    logic        ISSUE_READY, MEM_REQ, MEM_UNPRIV, MEM_ACK, RF_WE, DONE;
    logic        UNDEF, HINT, UNPRED, NOT_MINE;
    int          fails = 0;
    int          n_checks = 0;

    byte_load_decode_execute i_byte_load_decode_execute (.CLK(CLK), .NRST(NRST),
        .ISSUE_VALID(ISSUE_VALID), .ISSUE_WIDE(ISSUE_WIDE), .ISSUE_INSTR(ISSUE_INSTR),
        .ISSUE_PC(ISSUE_PC), .COND_PASS(COND_PASS), .MAIN_EXT(MAIN_EXT),
        .CARRY_FLAG(CARRY_FLAG), .ISSUE_READY(ISSUE_READY), .RF_RADDR_BASE(RF_RADDR_BASE),
        .RF_RADDR_INDEX(RF_RADDR_INDEX), .RF_RDATA_BASE(RF_RDATA_BASE),
        .RF_RDATA_INDEX(RF_RDATA_INDEX), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
        .MEM_UNPRIV(MEM_UNPRIV), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .RF_WE(RF_WE),
        .RF_WADDR(RF_WADDR), .RF_WDATA(RF_WDATA), .DONE(DONE), .UNDEF(UNDEF), .HINT(HINT),
        .UNPRED(UNPRED), .NOT_MINE(NOT_MINE));
    bl_mem_model i_bl_mem_model (.CLK(CLK), .NRST(NRST), .salt(salt), .lat(lat),
        .RF_RADDR_BASE(RF_RADDR_BASE), .RF_RADDR_INDEX(RF_RADDR_INDEX),
        .RF_RDATA_BASE(RF_RDATA_BASE), .RF_RDATA_INDEX(RF_RDATA_INDEX), .MEM_REQ(MEM_REQ),
        .MEM_ADDR(MEM_ADDR), .MEM_UNPRIV(MEM_UNPRIV), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));

    // 25 MHz core clock
    always #20 CLK = ~CLK;

    // Register value the model holds for register n
    function automatic logic [31:0] rv(input logic [3:0] n);
        return salt ^ ({28'h0, n} * 32'h1111_1111);
    endfunction

    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Summary and verdict; the only place the run ends
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Issue one instruction of form k (0 literal, 1 wide register, 2 unprivileged,
    // 3 short register, 4 foreign) and check everything it does at the ports
    task automatic run(input int k, input logic [3:0] rt, input logic [3:0] rn,
                       input logic [3:0] rm, input logic [11:0] imm, input logic u,
                       input logic cond, input logic mext);
        logic [31:0] ins, ea, base, off, ga;
        logic        lit, hint, undef, load, unp, gu;
        int          n, n1;
        case (k)
            0: ins = {8'hF8, u, 7'h1F, rt, imm};
            1: ins = {12'hF81, rn, rt, 6'h00, imm[1:0], rm};
            2: ins = {12'hF81, rn, rt, 4'hE, imm[7:0]};
            3: ins = {16'h0000, 7'h2E, rm[2:0], rn[2:0], rt[2:0]};
            default: ins = 32'h0000_0000;
        endcase
        @(negedge CLK);
        ISSUE_INSTR = ins;
        ISSUE_WIDE  = (k != 3);
        ISSUE_PC    = $urandom;
        COND_PASS   = cond;
        MAIN_EXT    = mext;
        CARRY_FLAG  = $urandom;
        lat         = $urandom_range(0, 3);
        salt        = $urandom;
        ISSUE_VALID = 1'b1;
        // Work out the expected outcome; base 1111 on wide forms falls to the literal form
        lit   = (k == 0) || ((k == 1 || k == 2) && rn == 4'hF);
        hint  = (lit || k == 1) && rt == 4'hF;
        undef = !hint && k < 3 && !mext;
        load  = k < 4 && !hint && !undef && cond;
        unp   = load && (((lit || k == 1) && rt == 4'hD) || (k == 1 && !lit
                && (rm == 4'hD || rm == 4'hF)) || (k == 2 && !lit && (rt == 4'hD || rt == 4'hF)));
        base  = ISSUE_PC & 32'hFFFF_FFFC;
        off   = {20'h0_0000, ins[11:0]};
        if (lit) ea = ins[23] ? base + off : base - off;
        else if (k == 1) ea = rv(rn) + (rv(rm) << imm[1:0]);
        else if (k == 2) ea = rv(rn) + {24'h00_0000, imm[7:0]};
        else ea = rv({1'b0, rn[2:0]}) + rv({1'b0, rm[2:0]});
        for (n = 0; n < 20 && ISSUE_READY !== 1'b1; n++) @(negedge CLK);
        // A block that never becomes ready again is a hang
        if (ISSUE_READY !== 1'b1) begin
            fails++;
            print_verdict();
        end
        @(negedge CLK);
        ISSUE_VALID = 1'b0;
        n1 = 0;
        for (n = 1; n < 40 && DONE !== 1'b1; n++) begin
            if (MEM_REQ === 1'b1 && n1 == 0) n1 = n;
            if (MEM_REQ === 1'b1) {ga, gu} = {MEM_ADDR, MEM_UNPRIV};
            @(negedge CLK);
        end
        if (n == 40) begin
            fails++;
            print_verdict();
        end
        check("not mine", NOT_MINE, k == 4);
        check("hint", HINT, hint);
        check("undefined", UNDEF, undef);
        check("unpredictable", UNPRED, unp);
        check("write enable", RF_WE, load);
        check("request cycle", n1, load ? 2 : 0);
        if (!load) check("no-effect latency", n, 1);
        if (load) begin
            check("address", ga, ea);
            check("unprivileged", gu, k == 2 && !lit);
            check("dest", RF_WADDR, k == 3 ? {1'b0, rt[2:0]} : rt);
            check("data", RF_WDATA, {24'h0, ga[7:0] ^ ga[15:8] ^ {gu, 7'h00}});
        end
    endtask

    // Reset, corner cases, then random traffic
    initial begin
        {NRST, ISSUE_VALID, ISSUE_WIDE, COND_PASS, MAIN_EXT, CARRY_FLAG} = 6'h00;
        {ISSUE_INSTR, ISSUE_PC, salt, lat} = '0;
        void'($urandom(32'h1ace));
        repeat (12) @(posedge CLK);
        @(negedge CLK) NRST = 1'b1;
        run(0, 4'h3, 4'h0, 4'h0, 12'hFFF, 1'b1, 1'b1, 1'b1);
        run(0, 4'h3, 4'h0, 4'h0, 12'hFFF, 1'b0, 1'b1, 1'b1);
        run(0, 4'h0, 4'h0, 4'h0, 12'h000, 1'b0, 1'b1, 1'b1);
        run(0, 4'hF, 4'h0, 4'h0, 12'h123, 1'b1, 1'b0, 1'b1);
        run(0, 4'hD, 4'h0, 4'h0, 12'h123, 1'b1, 1'b1, 1'b1);
        run(0, 4'h2, 4'h0, 4'h0, 12'h123, 1'b1, 1'b1, 1'b0);
        run(0, 4'h2, 4'h0, 4'h0, 12'h123, 1'b1, 1'b0, 1'b1);
        for (int s = 0; s < 4; s++) run(1, 4'h1, 4'h2, 4'h3, s, 1'b0, 1'b1, 1'b1);
        run(1, 4'hF, 4'h2, 4'h3, 12'h000, 1'b0, 1'b1, 1'b1);
        run(1, 4'h1, 4'hF, 4'h3, 12'h002, 1'b0, 1'b1, 1'b1);
        run(1, 4'h1, 4'h2, 4'hF, 12'h001, 1'b0, 1'b1, 1'b1);
        run(2, 4'h4, 4'h5, 4'h0, 12'h0FF, 1'b0, 1'b1, 1'b1);
        run(2, 4'h4, 4'hF, 4'h0, 12'h0FF, 1'b0, 1'b1, 1'b1);
        run(2, 4'hF, 4'h5, 4'h0, 12'h000, 1'b0, 1'b1, 1'b1);
        run(2, 4'h4, 4'h5, 4'h0, 12'h010, 1'b0, 1'b1, 1'b0);
        run(3, 4'h7, 4'h7, 4'h7, 12'h000, 1'b0, 1'b1, 1'b0);
        run(4, 4'h0, 4'h0, 4'h0, 12'h000, 1'b0, 1'b1, 1'b1);
        repeat (300) run($urandom_range(0, 4), $urandom, $urandom, $urandom, $urandom,
                         $urandom, ($urandom_range(0, 7) != 0), ($urandom_range(0, 7) != 0));
        print_verdict();
    end
endmodule
